// file: rtl/blit_map.svh
`ifndef BLIT_MAP_SVH
`define BLIT_MAP_SVH

// ==========================================
// Widths and depths
`define BLIT_WORD_W      16
`define BLIT_COORD_W     16
`define BLIT_PLANES      4
`define BLIT_QUEUE_DEPTH 16

// ==========================================
// Word packing
`define BLIT_PLANE_PIX   5'h10
`define BLIT_STEP_ONE    3'h1
`define BLIT_STEP_TWO    3'h2
`define BLIT_STEP_FOUR   3'h4

// ==========================================
// APB register offsets of the controller
`define BLIT_OFS_CMD     8'h00
`define BLIT_OFS_ARG     8'h04
`define BLIT_OFS_DATA    8'h08
`define BLIT_OFS_STAT    8'h0C

// ==========================================
// Command register fields
`define BLIT_CMD_OP_LSB   0
`define BLIT_CMD_STEP_LSB 4
`define BLIT_CMD_Z_BIT    8
`define BLIT_CMD_REL_BIT  9

// ==========================================
// Status register fields
`define BLIT_STAT_CMD_BIT  0
`define BLIT_STAT_DATA_BIT 1
`define BLIT_STAT_BUSY_BIT 2

`endif

// file: rtl/blit_pkg.sv
`default_nettype none

package blit_pkg;

   // ==========================================
   // Orders passed from controller to engine
   typedef enum logic [2:0]
   {
      OP_NONE,
      OP_SET_SIZE,
      OP_SET_PEN,
      OP_SET_ACT,
      OP_INPUT_AT,
      OP_INPUT_CUR
   } op_t;

endpackage : blit_pkg

`default_nettype wire

// file: rtl/blit_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "blit_map.svh"

interface blit_link_if;

   // ==========================================
   // Order channel
   logic                     cmd_valid;
   logic                     cmd_ready;
   blit_pkg::op_t            cmd_op;
   logic [2:0]               cmd_step;
   logic                     cmd_z;
   logic                     cmd_rel;
   logic [`BLIT_COORD_W-1:0] cmd_x;
   logic [`BLIT_COORD_W-1:0] cmd_y;

   // ==========================================
   // Block data channel, separate from orders
   logic                     dat_valid;
   logic                     dat_ready;
   logic [`BLIT_WORD_W-1:0]  dat_word;

   // Engine state
   logic                     busy;

   modport dev
   (
      input  cmd_valid, cmd_op, cmd_step, cmd_z, cmd_rel, cmd_x, cmd_y,
      input  dat_valid, dat_word,
      output cmd_ready, dat_ready, busy
   );

   modport host
   (
      output cmd_valid, cmd_op, cmd_step, cmd_z, cmd_rel, cmd_x, cmd_y,
      output dat_valid, dat_word,
      input  cmd_ready, dat_ready, busy
   );

endinterface : blit_link_if

`default_nettype wire

// file: rtl/blit_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module blit_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // Honest full and empty from the count
   assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rd_reg];

   // Storage, no reset needed
   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_reg] <= in_data_i;
   end

   // Pointers wrap only for power-of-two depth
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_reg    <= '0;
         rd_reg    <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= wr_reg + 1'b1;
         if (pop)
            rd_reg <= rd_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end

endmodule : blit_fifo

`default_nettype wire

// file: rtl/blit_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "blit_map.svh"

module blit_host
(
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RESET_I,
   // APB slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // Link to the engine
   blit_link_if.host        LINK
);

   logic        acc;
   logic        wr_cmd;
   logic        wr_dat;
   logic        done;
   logic        mapped;
   logic        cmd_pend_reg;
   logic        dat_pend_reg;
   logic [31:0] arg_reg;
   logic [31:0] rdata_reg;
   logic [9:0]  cmd_reg;
   logic [15:0] word_reg;

   // ==========================================
   // Decode; a write waits while its channel is still full
   assign acc    = PSEL_I && PENABLE_I;
   assign mapped = (PADDR_I == `BLIT_OFS_CMD) || (PADDR_I == `BLIT_OFS_ARG)
                || (PADDR_I == `BLIT_OFS_DATA) || (PADDR_I == `BLIT_OFS_STAT);
   assign wr_cmd = acc && PWRITE_I && (PADDR_I == `BLIT_OFS_CMD);
   assign wr_dat = acc && PWRITE_I && (PADDR_I == `BLIT_OFS_DATA);
   assign PREADY_O  = !(wr_cmd && cmd_pend_reg) && !(wr_dat && dat_pend_reg);
   assign PSLVERR_O = acc && !mapped;
   assign done      = acc && PREADY_O && mapped;
   assign PRDATA_O  = rdata_reg;

   // Read data latched in the setup cycle
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         rdata_reg <= '0;
      else if (PSEL_I && !PENABLE_I && !PWRITE_I)
      begin
         unique case (PADDR_I)
            `BLIT_OFS_CMD:  rdata_reg <= {22'h00_0000, cmd_reg};
            `BLIT_OFS_ARG:  rdata_reg <= arg_reg;
            `BLIT_OFS_STAT: rdata_reg <= {29'h0000_0000, LINK.busy,
                                          dat_pend_reg, cmd_pend_reg};
            default:        rdata_reg <= '0;
         endcase
      end
   end

   // Order holding register
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         cmd_reg      <= '0;
         arg_reg      <= '0;
         cmd_pend_reg <= 1'b0;
      end
      else
      begin
         if (done && PWRITE_I && PADDR_I == `BLIT_OFS_ARG)
            arg_reg <= PWDATA_I;
         if (done && wr_cmd)
         begin
            cmd_reg      <= PWDATA_I[9:0];
            cmd_pend_reg <= 1'b1;
         end
         else if (LINK.cmd_valid && LINK.cmd_ready)
            cmd_pend_reg <= 1'b0;
      end
   end

   // Block words only ever go to the data channel  see [R9]
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         word_reg     <= '0;
         dat_pend_reg <= 1'b0;
      end
      else if (done && wr_dat)
      begin
         word_reg     <= PWDATA_I[15:0];
         dat_pend_reg <= 1'b1;
      end
      else if (LINK.dat_valid && LINK.dat_ready)
         dat_pend_reg <= 1'b0;
   end

   // Link drive; software picks step by system size  see [R2]
   assign LINK.cmd_valid = cmd_pend_reg;
   assign LINK.cmd_op    = blit_pkg::op_t'(cmd_reg[`BLIT_CMD_OP_LSB +: 3]);
   assign LINK.cmd_step  = cmd_reg[`BLIT_CMD_STEP_LSB +: 3];
   assign LINK.cmd_z     = cmd_reg[`BLIT_CMD_Z_BIT];
   assign LINK.cmd_rel   = cmd_reg[`BLIT_CMD_REL_BIT];
   assign LINK.cmd_x     = arg_reg[15:0];
   assign LINK.cmd_y     = arg_reg[31:16];
   assign LINK.dat_valid = dat_pend_reg;
   assign LINK.dat_word  = word_reg;

endmodule : blit_host

`default_nettype wire

// file: rtl/blit_engine.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "blit_map.svh"

// ==========================================
// Block input engine
//
// Contract
// [R1] Three-bit step field sets X advance per word
// [R2] Host sets step 4, 2, 1 by size
// [R3] Order bit: clear by plane, set by pixel
// [R4] Explicit corner, optionally relative to pen
// [R5] Current variant starts at the pen
// [R6] Pen position never changes during transfer
// [R7] Block size comes from earlier size order
// [R8] No clipping; write all active planes
// [R9] Block words travel only through data queue
// [R10] Host sends whole words per scan line
// [R11] Plane mode: 16 pixels, leftmost bit first
// [R12] Step 1: one pixel on top nibble
// [R13] Fill lines left to right, top down
// [R14] Step 2: two pixels on upper byte
// [R15] Step 4: four pixels, leftmost top nibble
// [R16] Nibble bit order follows plane order
// [R17] Multi-device step 1/2 needs extra buffer
// [R18] Single device step 4 needs no buffer
// [R19] Empty queue stalls the transfer
module blit_engine
#(
   parameter int DEPTH = `BLIT_QUEUE_DEPTH
)
(
   // Clock and reset
   input  wire logic                     CLK_I,
   input  wire logic                     RESET_I,
   // Link from the controller
   blit_link_if.dev                      LINK,
   // Display memory write port
   output logic                          MEM_WE_O,
   output logic [`BLIT_COORD_W-1:0]      MEM_X_O,
   output logic [`BLIT_COORD_W-1:0]      MEM_Y_O,
   output logic [`BLIT_PLANES-1:0]       MEM_PIX_O,
   output logic [`BLIT_PLANES-1:0]       MEM_PLANE_O,
   // Pen position seen by the rest of the chip
   output logic [`BLIT_COORD_W-1:0]      PEN_X_O,
   output logic [`BLIT_COORD_W-1:0]      PEN_Y_O
);

   typedef enum logic {ST_IDLE, ST_XFER} state_t;

   localparam int CW = `BLIT_COORD_W;

   state_t                   state_reg;
   logic [CW-1:0]            width_reg;
   logic [CW-1:0]            height_reg;
   logic [CW-1:0]            pen_x_reg;
   logic [CW-1:0]            pen_y_reg;
   logic [`BLIT_PLANES-1:0]  act_reg;
   logic [2:0]               step_reg;
   logic                     z_reg;
   logic [CW-1:0]            base_x_reg;
   logic [CW-1:0]            base_y_reg;
   logic [CW-1:0]            col_reg;
   logic [CW-1:0]            row_reg;
   logic [4:0]               sub_reg;

   logic                     take;
   logic                     start;
   logic                     empty_blk;
   logic                     q_valid;
   logic                     q_pop;
   logic [`BLIT_WORD_W-1:0]  q_data;
   logic                     fire;
   logic                     line_end;
   logic                     word_end;
   logic                     blk_end;
   logic [4:0]               npw;
   logic [`BLIT_WORD_W-1:0]  bit_sh;
   logic [`BLIT_WORD_W-1:0]  nib_sh;
   logic [`BLIT_PLANES-1:0]  pix;

   // ==========================================
   // Block data queue between link and engine

   // Engine drains only while writing, so the queue really fills
   blit_fifo #(
      .WIDTH (`BLIT_WORD_W),
      .DEPTH (DEPTH)
   ) u_queue (
      .clk_i       (CLK_I),
      .reset_i     (RESET_I),
      .in_valid_i  (LINK.dat_valid),
      .in_ready_o  (LINK.dat_ready),
      .in_data_i   (LINK.dat_word),
      .out_valid_o (q_valid),
      .out_ready_i (q_pop),
      .out_data_o  (q_data)
   );

   // ==========================================
   // Order intake

   // Orders are taken only between transfers
   assign LINK.cmd_ready = (state_reg == ST_IDLE);
   assign LINK.busy      = (state_reg != ST_IDLE);
   assign take           = LINK.cmd_valid && LINK.cmd_ready;
   assign empty_blk      = (width_reg == '0) || (height_reg == '0);
   assign start          = take && !empty_blk
                        && (LINK.cmd_op == blit_pkg::OP_INPUT_AT
                         || LINK.cmd_op == blit_pkg::OP_INPUT_CUR);

   // Size, pen and plane state loaded by earlier orders
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         width_reg  <= '0;
         height_reg <= '0;
         pen_x_reg  <= '0;
         pen_y_reg  <= '0;
         act_reg    <= '1;
      end
      else if (take)
      begin
         unique case (LINK.cmd_op)
            blit_pkg::OP_SET_SIZE:
            begin
               width_reg  <= LINK.cmd_x;            // see [R7]
               height_reg <= LINK.cmd_y;
            end
            blit_pkg::OP_SET_PEN:
            begin
               pen_x_reg <= LINK.cmd_x;
               pen_y_reg <= LINK.cmd_y;
            end
            blit_pkg::OP_SET_ACT:
               act_reg <= LINK.cmd_x[`BLIT_PLANES-1:0];
            // Transfers leave the pen alone  see [R6]
            default:
               act_reg <= act_reg;
         endcase
      end
   end

   // Latch mode and upper-left corner at the start
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         step_reg   <= `BLIT_STEP_FOUR;
         z_reg      <= 1'b0;
         base_x_reg <= '0;
         base_y_reg <= '0;
      end
      else if (start)
      begin
         step_reg <= LINK.cmd_step;                 // see [R1]
         z_reg    <= LINK.cmd_z;                    // see [R3]
         if (LINK.cmd_op == blit_pkg::OP_INPUT_CUR)
         begin
            base_x_reg <= pen_x_reg;                // see [R5]
            base_y_reg <= pen_y_reg;
         end
         else if (LINK.cmd_rel)
         begin
            base_x_reg <= pen_x_reg + LINK.cmd_x;   // see [R4]
            base_y_reg <= pen_y_reg + LINK.cmd_y;
         end
         else
         begin
            base_x_reg <= LINK.cmd_x;
            base_y_reg <= LINK.cmd_y;
         end
      end
   end

   // ==========================================
   // Pixel walk

   // Pixels per word; any step code other than 4 or 2 acts as one pixel
   always_comb
   begin
      if (!z_reg)
         npw = `BLIT_PLANE_PIX;                     // see [R11]
      else if (step_reg == `BLIT_STEP_FOUR)
         npw = 5'h04;                               // see [R15]
      else if (step_reg == `BLIT_STEP_TWO)
         npw = 5'h02;                               // see [R14]
      else
         npw = 5'h01;                               // see [R12]
   end

   // A pixel goes out only when a word waits  see [R19]
   assign fire     = (state_reg == ST_XFER) && q_valid;
   assign line_end = (col_reg == width_reg - 1'b1);
   assign word_end = (sub_reg == npw - 1'b1);
   assign blk_end  = line_end && (row_reg == height_reg - 1'b1);
   // Unused tail of a line's last word is dropped  see [R10]
   assign q_pop    = fire && (line_end || word_end);

   // Leftmost pixel sits in the top bits of the word
   assign bit_sh = q_data << sub_reg;
   assign nib_sh = q_data << {sub_reg[3:0], 2'b00};
   // Nibble bit i feeds plane i  see [R16]
   assign pix    = z_reg ? nib_sh[15:12] : {`BLIT_PLANES{bit_sh[15]}};

   // Walk state
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         state_reg <= ST_IDLE;
      else if (start)
         state_reg <= ST_XFER;
      else if (fire && blk_end)
         state_reg <= ST_IDLE;
   end

   // Left to right, then next line down  see [R13]
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I || start)
      begin
         col_reg <= '0;
         row_reg <= '0;
         sub_reg <= '0;
      end
      else if (fire)
      begin
         sub_reg <= (line_end || word_end) ? 5'h00 : sub_reg + 1'b1;
         if (line_end)
         begin
            col_reg <= '0;
            row_reg <= row_reg + 1'b1;
         end
         else
            col_reg <= col_reg + 1'b1;
      end
   end

   // ==========================================
   // Memory write port, registered

   // No clip test; all active planes written  see [R8]
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         MEM_WE_O    <= 1'b0;
         MEM_X_O     <= '0;
         MEM_Y_O     <= '0;
         MEM_PIX_O   <= '0;
         MEM_PLANE_O <= '0;
      end
      else
      begin
         MEM_WE_O <= fire;
         if (fire)
         begin
            MEM_X_O     <= base_x_reg + col_reg;
            MEM_Y_O     <= base_y_reg + row_reg;
            MEM_PIX_O   <= pix;
            MEM_PLANE_O <= act_reg;
         end
      end
   end

   assign PEN_X_O = pen_x_reg;
   assign PEN_Y_O = pen_y_reg;

endmodule : blit_engine

`default_nettype wire

// file: tb/blit_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "blit_map.svh"

module blit_link_monitor
(
   // Clock and reset
   input wire logic                     CLK_I,
   input wire logic                     RESET_I,
   // Link signals
   input wire logic                     cmd_valid,
   input wire logic                     cmd_ready,
   input wire blit_pkg::op_t            cmd_op,
   input wire logic                     cmd_rel,
   input wire logic [`BLIT_COORD_W-1:0] cmd_x,
   input wire logic [`BLIT_COORD_W-1:0] cmd_y,
   input wire logic                     dat_ready,
   input wire logic                     busy,
   // Engine outputs
   input wire logic                     MEM_WE_O,
   input wire logic [`BLIT_COORD_W-1:0] MEM_X_O,
   input wire logic [`BLIT_COORD_W-1:0] MEM_Y_O,
   input wire logic [`BLIT_PLANES-1:0]  MEM_PLANE_O,
   input wire logic [`BLIT_COORD_W-1:0] PEN_X_O,
   input wire logic [`BLIT_COORD_W-1:0] PEN_Y_O
);
   // ==========================================
   // Shadow of the engine state
   logic        take;
   logic        is_in;
   logic [15:0] w_reg, h_reg, cx_reg, cy_reg, dx, dy;
   logic [3:0]  act_reg;

   // Accepted orders and offset inside the block
   assign take  = cmd_valid && cmd_ready;
   assign is_in = cmd_op == blit_pkg::OP_INPUT_AT || cmd_op == blit_pkg::OP_INPUT_CUR;
   assign dx    = MEM_X_O - cx_reg;
   assign dy    = MEM_Y_O - cy_reg;

   // Block size, kept until the next size order
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         w_reg <= 16'h0000;
         h_reg <= 16'h0000;
      end
      else if (take && cmd_op == blit_pkg::OP_SET_SIZE)
      begin
         w_reg <= cmd_x;
         h_reg <= cmd_y;
      end
   end

   // Activity mask, all planes after reset
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         act_reg <= 4'hF;
      else if (take && cmd_op == blit_pkg::OP_SET_ACT)
         act_reg <= cmd_x[3:0];
   end

   // Corner; relative add wraps like the engine
   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         cx_reg <= 16'h0000;
         cy_reg <= 16'h0000;
      end
      else if (take && is_in)
      begin
         cx_reg <= (cmd_op == blit_pkg::OP_INPUT_CUR) ? PEN_X_O
                 : (cmd_rel ? PEN_X_O + cmd_x : cmd_x);
         cy_reg <= (cmd_op == blit_pkg::OP_INPUT_CUR) ? PEN_Y_O
                 : (cmd_rel ? PEN_Y_O + cmd_y : cmd_y);
      end
   end

   // ==========================================
   // Properties
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   pen_stable_a: assert property (busy |-> $stable(PEN_X_O) && $stable(PEN_Y_O))
      else $error("pen moved during transfer");
   start_busy_a: assert property (take && is_in && w_reg != 0 && h_reg != 0 |=> busy)
      else $error("transfer did not start");
   zero_drop_a: assert property (take && is_in && (w_reg == 0 || h_reg == 0) |=> !busy)
      else $error("empty block started");
   plane_mask_a: assert property (MEM_WE_O |-> MEM_PLANE_O == act_reg)
      else $error("plane enables differ from activity");
   in_rect_a: assert property (MEM_WE_O |-> dx < w_reg && dy < h_reg)
      else $error("write outside block");
   row_step_a: assert property (MEM_WE_O && $past(MEM_WE_O)
      && MEM_Y_O == $past(MEM_Y_O) |-> MEM_X_O == $past(MEM_X_O) + 16'h0001)
      else $error("x did not advance by one");
   line_wrap_a: assert property (MEM_WE_O && $past(MEM_WE_O)
      && MEM_Y_O != $past(MEM_Y_O) |-> MEM_Y_O == $past(MEM_Y_O) + 16'h0001 && MEM_X_O == cx_reg)
      else $error("bad line change");
   we_in_xfer_a: assert property (MEM_WE_O |-> busy || $past(busy))
      else $error("write outside transfer");
   order_drop_a: assert property (take |=> !cmd_valid)
      else $error("order held after acceptance");
   busy_refuse_a: assert property (busy |-> !cmd_ready)
      else $error("order accepted during transfer");

   // Main scenarios reached
   start_c: cover property ($rose(busy));
   wrap_c: cover property (MEM_WE_O && MEM_Y_O != cy_reg);
   full_c: cover property (!dat_ready && !busy);

endmodule : blit_link_monitor

`default_nettype wire

// file: tb/block_input_transfer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "blit_map.svh"

module block_input_transfer_tb;
   // ==========================================
   // Stimulus and observed signals
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, mem_we, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] mem_x, mem_y, pen_x, pen_y;
   logic [3:0]  mem_pix, mem_plane, act_exp;
   logic [39:0] exp_q[$];
   int          failures, checks, cycles, seq;

   blit_link_if link();

   blit_host u_blit_host
   (
      .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .LINK(link)
   );
   blit_engine #(.DEPTH(16)) u_blit_engine
   (
      .CLK_I(clk), .RESET_I(rst), .LINK(link), .MEM_WE_O(mem_we), .MEM_X_O(mem_x),
      .MEM_Y_O(mem_y), .MEM_PIX_O(mem_pix), .MEM_PLANE_O(mem_plane),
      .PEN_X_O(pen_x), .PEN_Y_O(pen_y)
   );
   blit_link_monitor u_blit_link_monitor
   (
      .CLK_I(clk), .RESET_I(rst), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
      .cmd_op(link.cmd_op), .cmd_rel(link.cmd_rel), .cmd_x(link.cmd_x), .cmd_y(link.cmd_y),
      .dat_ready(link.dat_ready), .busy(link.busy), .MEM_WE_O(mem_we), .MEM_X_O(mem_x),
      .MEM_Y_O(mem_y), .MEM_PLANE_O(mem_plane), .PEN_X_O(pen_x), .PEN_Y_O(pen_y)
   );

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ==========================================
   // Common tasks
   task conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task check(input logic [39:0] seen, input logic [39:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // One APB transfer; waits for the slave without assuming a latency
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Argument first, then the order that uses it
   task order(input blit_pkg::op_t op, input logic rel, input logic [2:0] step, input logic z,
              input logic [15:0] x, input logic [15:0] y);
      apb(1'b1, `BLIT_OFS_ARG, {y, x});
      apb(1'b1, `BLIT_OFS_CMD, {22'h00_0000, rel, z, 1'b0, step, 1'b0, op});
   endtask : order

   // Builds words and expected pixels, runs one block, waits for idle
   task automatic do_block(input blit_pkg::op_t op, input logic rel, input logic [2:0] step,
                 input logic z, input int w, input int h, input int ax, input int ay,
                 input int cx, input int cy, input logic pre);
      int          ppw, n;
      logic [15:0] wd;
      logic [15:0] wq[$];
      logic [3:0]  px;
      ppw = !z ? 16 : (step == 3'h4 ? 4 : (step == 3'h2 ? 2 : 1));
      n = (w + ppw - 1) / ppw;
      for (int r = 0; r < h; r++)
         for (int k = 0; k < n; k++)
         begin
            wd = 16'h6C1B + 16'h3F95 * 16'(seq);
            seq++;
            wq.push_back(wd);
            for (int j = 0; j < ppw; j++)
               if (k * ppw + j < w)
               begin
                  px = z ? wd[15-4*j -: 4] : {4{wd[15-j]}};
                  exp_q.push_back({16'(cx + k * ppw + j), 16'(cy + r), px, act_exp});
               end
         end
      if (!pre)
      begin
         order(blit_pkg::OP_SET_SIZE, 1'b0, 3'h0, 1'b0, 16'(w), 16'(h));
         order(op, rel, step, z, 16'(ax), 16'(ay));
      end
      foreach (wq[i])
         apb(1'b1, `BLIT_OFS_DATA, {16'h0000, wq[i]});
      if (pre)
      begin
         apb(1'b0, `BLIT_OFS_STAT, 32'h0000_0000);
         check(rd[2:0], 3'h2, "queue full with word pending");
         order(blit_pkg::OP_SET_SIZE, 1'b0, 3'h0, 1'b0, 16'(w), 16'(h));
         order(op, rel, step, z, 16'(ax), 16'(ay));
      end
      while (exp_q.size() != 0)
         @(posedge clk);
      do
         apb(1'b0, `BLIT_OFS_STAT, 32'h0000_0000);
      while (rd[`BLIT_STAT_BUSY_BIT] !== 1'b0);
   endtask : do_block

   // ==========================================
   // Scenarios
   task t_reset();
      apb(1'b0, `BLIT_OFS_STAT, 32'h0000_0000);
      check(rd, 32'h0000_0000, "status after reset");
      apb(1'b0, 8'h10, 32'h0000_0000);
      check({err, rd}, {8'h01, 32'h0000_0000}, "unmapped read");
   endtask : t_reset

   // Plane mode and the three pixel packings
   task t_modes();
      do_block(blit_pkg::OP_INPUT_AT, 1'b0, 3'h4, 1'b0, 17, 2, 5, 7, 5, 7, 1'b0);
      do_block(blit_pkg::OP_INPUT_AT, 1'b0, 3'h4, 1'b1, 17, 2, 100, 3, 100, 3, 1'b0);
      do_block(blit_pkg::OP_INPUT_AT, 1'b0, 3'h2, 1'b1, 3, 2, 0, 0, 0, 0, 1'b0);
      do_block(blit_pkg::OP_INPUT_AT, 1'b0, 3'h1, 1'b1, 2, 2, 9, 9, 9, 9, 1'b0);
   endtask : t_modes

   // Whole block sent before the order arrives: queue full, last word pending
   task t_full();
      do_block(blit_pkg::OP_INPUT_AT, 1'b0, 3'h4, 1'b0, 16, 17, 0, 40, 0, 40, 1'b1);
   endtask : t_full

   task t_rel_cur();
      order(blit_pkg::OP_SET_PEN, 1'b0, 3'h0, 1'b0, 16'h000A, 16'h0014);
      order(blit_pkg::OP_SET_ACT, 1'b0, 3'h0, 1'b0, 16'h0005, 16'h0000);
      act_exp = 4'h5;
      do_block(blit_pkg::OP_INPUT_AT, 1'b1, 3'h4, 1'b1, 5, 1, 3, 4, 13, 24, 1'b0);
      do_block(blit_pkg::OP_INPUT_CUR, 1'b0, 3'h4, 1'b1, 4, 2, 0, 0, 10, 20, 1'b0);
      check({pen_x, pen_y}, {16'h000A, 16'h0014}, "pen after transfers");
   endtask : t_rel_cur

   task t_zero();
      order(blit_pkg::OP_SET_SIZE, 1'b0, 3'h0, 1'b0, 16'h0000, 16'h0003);
      order(blit_pkg::OP_INPUT_AT, 1'b0, 3'h4, 1'b0, 16'h0000, 16'h0000);
      apb(1'b0, `BLIT_OFS_STAT, 32'h0000_0000);
      check(rd[2:0], 3'h0, "empty block stays idle");
   endtask : t_zero

   // Pixel port watcher; registered outputs read before the edge updates them
   always @(posedge clk)
      if (mem_we === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(1'b1, 1'b0, "unexpected pixel write");
         else
            check({mem_x, mem_y, mem_pix, mem_plane}, exp_q.pop_front(), "pixel");
      end

   // Hang guard, far above the several hundred cycles needed
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         conclude();
      end
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      failures = 0;
      checks = 0;
      cycles = 0;
      seq = 0;
      act_exp = 4'hF;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_modes();
      t_rel_cur();
      t_zero();
      t_full();
      conclude();
   end

endmodule : block_input_transfer_tb

`default_nettype wire
